// >>> hw/ipsw_defines.vh
// constants for the interrupt priority and standby wake controller
`ifndef IPSW_DEFINES_VH
`define IPSW_DEFINES_VH

// vector addresses
`define IPSW_VEC_W 17
`define IPSW_VEC_0 17'h00003
`define IPSW_VEC_1 17'h0000b
`define IPSW_VEC_2 17'h00013
`define IPSW_VEC_3 17'h0001b
`define IPSW_VEC_4 17'h00023
`define IPSW_VEC_5 17'h0002b
`define IPSW_VEC_6 17'h00033
`define IPSW_VEC_7 17'h0003b
`define IPSW_VEC_8 17'h00043
`define IPSW_VEC_9 17'h0004b
`define IPSW_NVEC 10

// level encodings; none means no service in progress
`define IPSW_LVL_NONE 2'h0
`define IPSW_LVL_LOW 2'h1
`define IPSW_LVL_HIGH 2'h2
`define IPSW_LVL_TOP 2'h3

// standby states
`define IPSW_ST_RUN 2'h0
`define IPSW_ST_HALT 2'h1
`define IPSW_ST_HOLD 2'h2
`define IPSW_ST_XHOLD 2'h3

// base timer clock source encodings
`define IPSW_BTCK_SUB 2'h0
`define IPSW_BTCK_LRC 2'h1
`define IPSW_BTCK_SYS 2'h2
`define IPSW_BTCK_T0P 2'h3

// nesting depth of the service level stack
`define IPSW_DEPTH 3
`define IPSW_SP_W 2
`define IPSW_SP_FULL 2'h3
`define IPSW_SP_ZERO 2'h0
`define IPSW_SP_ONE 2'h1

`endif

// >>> hw/ipsw_controller.v
// interrupt priority arbiter and standby wake controller
`timescale 1ns/1ps
`include "ipsw_defines.vh"


module ipsw_controller (
	input wire clk_sys,
	input wire rst,
	input wire reset_pin_n,
	input wire watchdog_reset,
	input wire low_voltage_reset,
	input wire ext_irq_pin_a,
	input wire ext_irq_pin_b,
	input wire ext_irq_pin_c,
	input wire ext_irq_pin_d,
	input wire ext_irq_pin_e,
	input wire pin_a_level_mode,
	input wire pin_b_level_mode,
	input wire supply_level_detect_irq,
	input wire base_timer_irq,
	input wire timer_zero_low_irq,
	input wire timer_zero_high_irq,
	input wire timer_a_low_irq,
	input wire timer_a_high_irq,
	input wire timer_one_low_irq,
	input wire timer_one_high_irq,
	input wire serial_unit_irq,
	input wire adc_irq,
	input wire port_zero_irq,
	input wire [9:0] vec_level_sel,
	input wire [9:0] vec_enable,
	input wire [1:0] base_timer_clk_sel,
	input wire lrc_on_request,
	input wire xtal_on_request,
	input wire halt_request,
	input wire hold_request,
	input wire xhold_request,
	input wire irq_ack,
	input wire irq_return,
	output reg irq_req,
	output reg [16:0] irq_vector,
	output reg [1:0] irq_level,
	output reg [1:0] service_level,
	output reg [1:0] standby_state,
	output reg cpu_run,
	output reg periph_run,
	output reg base_timer_run,
	output reg ceramic_oscillator_en,
	output reg mrc_osc_en,
	output reg lrc_osc_en,
	output reg xtal_osc_en,
	output reg wake_reset
);

	// ************************************************************
	// input synchronisers
	// ************************************************************
	// pins come from outside the clock domain; internal sources do not
	reg [4:0] pin_s1_reg;
	reg [4:0] pin_s2_reg;
	reg rstpin_s1_reg;
	reg rstpin_s2_reg;

	always @(posedge clk_sys) begin
		if (rst) begin
			pin_s1_reg <= 5'h00;
			pin_s2_reg <= 5'h00;
			rstpin_s1_reg <= 1'b1;
			rstpin_s2_reg <= 1'b1;
		end else begin
			pin_s1_reg <= {ext_irq_pin_e, ext_irq_pin_d, ext_irq_pin_c,
				ext_irq_pin_b, ext_irq_pin_a};
			pin_s2_reg <= pin_s1_reg;
			rstpin_s1_reg <= reset_pin_n;
			rstpin_s2_reg <= rstpin_s1_reg;
		end
	end

	wire pa = pin_s2_reg[0];
	wire pb = pin_s2_reg[1];
	wire pc = pin_s2_reg[2];
	wire pd = pin_s2_reg[3];
	wire pe = pin_s2_reg[4];

	// ************************************************************
	// source to vector mapping
	// ************************************************************
	wire [9:0] vec_src;
	assign vec_src[0] = pa | supply_level_detect_irq;
	assign vec_src[1] = pb;
	assign vec_src[2] = pc | pe | timer_zero_low_irq | timer_a_low_irq;
	assign vec_src[3] = pd | base_timer_irq;
	assign vec_src[4] = timer_zero_high_irq | timer_a_high_irq;
	assign vec_src[5] = timer_one_low_irq | timer_one_high_irq;
	assign vec_src[6] = 1'b0;
	assign vec_src[7] = serial_unit_irq;
	assign vec_src[8] = adc_irq;
	assign vec_src[9] = port_zero_irq;

	wire [9:0] pending = vec_src & vec_enable;

	// level of vector i: the first two choose top or low, the rest high or low
	function [1:0] ipsw_vec_level;
		input integer idx;
		input sel;
		begin
			if (!sel)
				ipsw_vec_level = `IPSW_LVL_LOW;
			else if (idx < 2)
				ipsw_vec_level = `IPSW_LVL_TOP;
			else
				ipsw_vec_level = `IPSW_LVL_HIGH;
		end
	endfunction

	function [16:0] ipsw_vec_addr;
		input integer idx;
		begin
			case (idx)
			0: ipsw_vec_addr = `IPSW_VEC_0;
			1: ipsw_vec_addr = `IPSW_VEC_1;
			2: ipsw_vec_addr = `IPSW_VEC_2;
			3: ipsw_vec_addr = `IPSW_VEC_3;
			4: ipsw_vec_addr = `IPSW_VEC_4;
			5: ipsw_vec_addr = `IPSW_VEC_5;
			6: ipsw_vec_addr = `IPSW_VEC_6;
			7: ipsw_vec_addr = `IPSW_VEC_7;
			8: ipsw_vec_addr = `IPSW_VEC_8;
			default: ipsw_vec_addr = `IPSW_VEC_9;
			endcase
		end
	endfunction

	// ************************************************************
	// arbitration
	// ************************************************************
	// scanning from the highest index down leaves the smallest address
	// standing among equal levels; a strictly higher level always replaces
	reg [1:0] win_level;
	reg [16:0] win_addr;
	reg win_valid;
	reg [1:0] lv;
	integer i;

	always @* begin
		win_level = `IPSW_LVL_NONE;
		win_addr = `IPSW_VEC_0;
		win_valid = 1'b0;
		lv = `IPSW_LVL_NONE;
		for (i = `IPSW_NVEC - 1; i >= 0; i = i - 1) begin
			lv = ipsw_vec_level(i, vec_level_sel[i]);
			if (pending[i] && (lv >= win_level)) begin
				win_level = lv;
				win_addr = ipsw_vec_addr(i);
				win_valid = 1'b1;
			end
		end
	end

	// only strictly higher than the current service level may be taken
	wire can_take = win_valid && (win_level > service_level);

	// ************************************************************
	// service level stack
	// ************************************************************
	reg [1:0] lvl_stack [0:`IPSW_DEPTH-1];
	reg [`IPSW_SP_W-1:0] sp_reg;
	integer k;

	always @(posedge clk_sys) begin
		if (rst) begin
			sp_reg <= `IPSW_SP_ZERO;
			service_level <= `IPSW_LVL_NONE;
			for (k = 0; k < `IPSW_DEPTH; k = k + 1)
				lvl_stack[k] <= `IPSW_LVL_NONE;
		end else if (irq_ack && irq_req && sp_reg != `IPSW_SP_FULL) begin
			lvl_stack[sp_reg] <= service_level;
			sp_reg <= sp_reg + `IPSW_SP_ONE;
			service_level <= irq_level;
		end else if (irq_return && sp_reg != `IPSW_SP_ZERO) begin
			sp_reg <= sp_reg - `IPSW_SP_ONE;
			service_level <= lvl_stack[sp_reg - `IPSW_SP_ONE];
		end
	end

	// the request is dropped on the ack edge so it is not taken twice
	always @(posedge clk_sys) begin
		if (rst) begin
			irq_req <= 1'b0;
			irq_vector <= `IPSW_VEC_0;
			irq_level <= `IPSW_LVL_NONE;
		end else begin
			irq_req <= can_take && !(irq_ack && irq_req) && !irq_return;
			irq_vector <= win_addr;
			irq_level <= win_level;
		end
	end

	// ************************************************************
	// standby wake sources
	// ************************************************************
	wire any_reset = !rstpin_s2_reg || watchdog_reset || low_voltage_reset;
	wire halt_wake = any_reset || (|pending);
	wire hold_wake = any_reset || (pa && pin_a_level_mode)
		|| (pb && pin_b_level_mode) || pc || pe
		|| port_zero_irq || supply_level_detect_irq;
	wire bt_clk_slow = (base_timer_clk_sel == `IPSW_BTCK_SUB) ||
		(base_timer_clk_sel == `IPSW_BTCK_LRC);
	wire xhold_wake = hold_wake || (base_timer_irq && bt_clk_slow);

	// ************************************************************
	// standby state machine
	// ************************************************************
	reg [1:0] st_next;
	reg xtal_keep_reg;
	reg lrc_keep_reg;

	always @* begin
		st_next = standby_state;
		case (standby_state)
		`IPSW_ST_RUN: begin
			if (xhold_request)
				st_next = `IPSW_ST_XHOLD;
			else if (hold_request)
				st_next = `IPSW_ST_HOLD;
			else if (halt_request)
				st_next = `IPSW_ST_HALT;
		end
		`IPSW_ST_HALT: begin
			if (halt_wake)
				st_next = `IPSW_ST_RUN;
		end
		`IPSW_ST_HOLD: begin
			if (hold_wake)
				st_next = `IPSW_ST_RUN;
		end
		`IPSW_ST_XHOLD: begin
			if (xhold_wake)
				st_next = `IPSW_ST_RUN;
		end
		default: st_next = `IPSW_ST_RUN;
		endcase
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			standby_state <= `IPSW_ST_RUN;
			xtal_keep_reg <= 1'b0;
			lrc_keep_reg <= 1'b0;
			wake_reset <= 1'b0;
		end else begin
			standby_state <= st_next;
			wake_reset <= (standby_state != `IPSW_ST_RUN) &&
				(st_next == `IPSW_ST_RUN) && any_reset;
			// crystal state, and lrc state when the lrc clocks the base timer, is frozen at crystal hold entry
			if (standby_state == `IPSW_ST_RUN &&
				st_next == `IPSW_ST_XHOLD) begin
				xtal_keep_reg <= xtal_on_request;
				lrc_keep_reg <= lrc_on_request &&
					(base_timer_clk_sel == `IPSW_BTCK_LRC);
			end
		end
	end

	// ************************************************************
	// clock and run controls
	// ************************************************************
	// the watchdog owns the low-speed rc in hold; we pass its request on
	always @(posedge clk_sys) begin
		if (rst) begin
			cpu_run <= 1'b1;
			periph_run <= 1'b1;
			base_timer_run <= 1'b1;
			ceramic_oscillator_en <= 1'b1;
			mrc_osc_en <= 1'b1;
			lrc_osc_en <= 1'b1;
			xtal_osc_en <= 1'b0;
		end else begin
			case (st_next)
			`IPSW_ST_HALT: begin
				cpu_run <= 1'b0;
				periph_run <= 1'b1;
				base_timer_run <= 1'b1;
				ceramic_oscillator_en <= 1'b1;
				mrc_osc_en <= 1'b1;
				lrc_osc_en <= lrc_on_request;
				xtal_osc_en <= xtal_on_request;
			end
			`IPSW_ST_HOLD: begin
				cpu_run <= 1'b0;
				periph_run <= 1'b0;
				base_timer_run <= 1'b0;
				ceramic_oscillator_en <= 1'b0;
				mrc_osc_en <= 1'b0;
				lrc_osc_en <= lrc_on_request;
				xtal_osc_en <= 1'b0;
			end
			`IPSW_ST_XHOLD: begin
				cpu_run <= 1'b0;
				periph_run <= 1'b0;
				base_timer_run <= 1'b1;
				ceramic_oscillator_en <= 1'b0;
				mrc_osc_en <= 1'b0;
				lrc_osc_en <= (standby_state != `IPSW_ST_XHOLD) ?
					lrc_on_request : lrc_keep_reg | (lrc_on_request &
					(base_timer_clk_sel != `IPSW_BTCK_LRC));
				xtal_osc_en <= (standby_state != `IPSW_ST_XHOLD) ?
					xtal_on_request : xtal_keep_reg;
			end
			default: begin
				cpu_run <= 1'b1;
				periph_run <= 1'b1;
				base_timer_run <= 1'b1;
				ceramic_oscillator_en <= 1'b1;
				mrc_osc_en <= 1'b1;
				lrc_osc_en <= lrc_on_request;
				xtal_osc_en <= xtal_on_request;
			end
			endcase
		end
	end

endmodule // ipsw_controller

// >>> sim/ipsw_checker.sv
// port assertions for the interrupt arbiter and standby controller
`timescale 1ns/1ps
module ipsw_checker (
	input wire clk_sys,
	input wire rst,
	input wire watchdog_reset,
	input wire port_zero_irq,
	input wire base_timer_irq,
	input wire [1:0] base_timer_clk_sel,
	input wire irq_ack,
	input wire irq_req,
	input wire [16:0] irq_vector,
	input wire [1:0] irq_level,
	input wire [1:0] service_level,
	input wire [1:0] standby_state,
	input wire cpu_run,
	input wire periph_run,
	input wire base_timer_run,
	input wire ceramic_oscillator_en,
	input wire mrc_osc_en,
	input wire xtal_osc_en
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ************
	// assertions
	// ************
	refuse_equal_a: assert property (irq_req |-> irq_level > service_level)
		else $error("request not above service level");
	vector_map_a: assert property (irq_req |-> irq_vector[2:0] == 3'h3
		&& irq_vector <= 17'h0004b && irq_vector != 17'h00033)
		else $error("vector outside the table");
	level_push_a: assert property (irq_ack && irq_req
		|=> service_level == $past(irq_level))
		else $error("service level not raised on ack");
	halt_run_a: assert property (standby_state == 2'h1
		|-> !cpu_run && periph_run && ceramic_oscillator_en)
		else $error("halt stopped the wrong parts");
	hold_stop_a: assert property (standby_state == 2'h2 |-> !periph_run
		&& !ceramic_oscillator_en && !mrc_osc_en && !xtal_osc_en)
		else $error("hold left something running");
	xhold_bt_a: assert property (standby_state == 2'h3 |-> base_timer_run
		&& !periph_run && !ceramic_oscillator_en && !mrc_osc_en)
		else $error("crystal hold controls wrong");
	xtal_keep_a: assert property (standby_state == 2'h3
		&& $past(standby_state) == 2'h3 |-> $stable(xtal_osc_en))
		else $error("crystal changed in crystal hold");
	port_wake_a: assert property (standby_state == 2'h2 && port_zero_irq
		|=> standby_state == 2'h0)
		else $error("port request did not end hold");
	bt_wake_a: assert property (standby_state == 2'h3 && base_timer_irq
		&& !base_timer_clk_sel[1] |=> standby_state == 2'h0)
		else $error("base timer did not end crystal hold");
	wdog_wake_a: assert property (standby_state != 2'h0 && watchdog_reset
		|=> standby_state == 2'h0)
		else $error("watchdog did not end standby");
	cover property (irq_ack && irq_req);
	cover property (standby_state == 2'h2 && port_zero_irq);
	cover property (standby_state == 2'h3 && base_timer_irq);
endmodule // ipsw_checker

bind ipsw_controller ipsw_checker chk_i (.clk_sys(clk_sys), .rst(rst),
	.watchdog_reset(watchdog_reset), .port_zero_irq(port_zero_irq),
	.base_timer_irq(base_timer_irq), .base_timer_clk_sel(base_timer_clk_sel),
	.irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector),
	.irq_level(irq_level), .service_level(service_level),
	.standby_state(standby_state), .cpu_run(cpu_run), .periph_run(periph_run),
	.base_timer_run(base_timer_run), .mrc_osc_en(mrc_osc_en),
	.ceramic_oscillator_en(ceramic_oscillator_en), .xtal_osc_en(xtal_osc_en));

// >>> sim/ipsw_core_model.sv
// core model that takes a vector after a set delay
`timescale 1ns/1ps
module ipsw_core_model (
	input wire clk_sys,
	input wire rst,
	input wire irq_req,
	input wire [3:0] ack_delay,
	output reg irq_ack
);
	// delay 4'hf means the core never takes a vector
	reg [3:0] wait_reg;
	always @(posedge clk_sys) begin
		if (rst || !irq_req || irq_ack) begin
			wait_reg <= 4'h0;
			irq_ack <= 1'b0;
		end else if (ack_delay != 4'hf && wait_reg >= ack_delay) begin
			irq_ack <= 1'b1;
		end else begin
			wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule // ipsw_core_model

// >>> sim/ipsw_controller_bench.sv
// self-checking bench for the interrupt and standby controller
`timescale 1ns/1ps
module ipsw_controller_bench;
	reg clk_sys = 1'b0, rst = 1'b1, wdog = 1'b0, ret = 1'b0, pa_lm = 1'b0;
	reg [15:0] src = 16'h0;
	reg [9:0] lsel = 10'h0;
	reg [1:0] bt_sel = 2'h0;
	reg lrc_q = 1'b1, xtal_q = 1'b0, halt_q = 1'b0, hold_q = 1'b0;
	reg xhold_q = 1'b0;
	reg rpin_n = 1'b1, lvr = 1'b0, pb_lm = 1'b1;
	reg [3:0] dly = 4'hf;
	wire ack, irq_req, cpu_run, periph_run, base_timer_run, ceramic_oscillator_en;
	wire mrc_osc_en, lrc_osc_en, xtal_osc_en, wake_reset;
	wire [16:0] irq_vector;
	wire [1:0] irq_level, service_level, standby_state;
	int errors = 0, n_compared = 0, cyc = 0;
	// low byte of the vector that each source bit lands on
	reg [7:0] vt [16] = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h13, 8'h03, 8'h1b,
		8'h13, 8'h23, 8'h13, 8'h23, 8'h2b, 8'h2b, 8'h3b, 8'h43, 8'h4b};
	ipsw_controller DUT (.clk_sys(clk_sys), .rst(rst), .reset_pin_n(rpin_n),
		.watchdog_reset(wdog), .low_voltage_reset(lvr),
		.ext_irq_pin_a(src[0]), .ext_irq_pin_b(src[1]), .ext_irq_pin_c(src[2]),
		.ext_irq_pin_d(src[3]), .ext_irq_pin_e(src[4]),
		.pin_a_level_mode(pa_lm), .pin_b_level_mode(pb_lm),
		.supply_level_detect_irq(src[5]), .base_timer_irq(src[6]),
		.timer_zero_low_irq(src[7]), .timer_zero_high_irq(src[8]),
		.timer_a_low_irq(src[9]), .timer_a_high_irq(src[10]),
		.timer_one_low_irq(src[11]), .timer_one_high_irq(src[12]),
		.serial_unit_irq(src[13]), .adc_irq(src[14]), .port_zero_irq(src[15]),
		.vec_level_sel(lsel), .vec_enable(10'h3ff), .base_timer_clk_sel(bt_sel),
		.lrc_on_request(lrc_q), .xtal_on_request(xtal_q), .halt_request(halt_q),
		.hold_request(hold_q), .xhold_request(xhold_q), .irq_ack(ack),
		.irq_return(ret), .irq_req(irq_req), .irq_vector(irq_vector),
		.irq_level(irq_level), .service_level(service_level),
		.standby_state(standby_state), .cpu_run(cpu_run),
		.periph_run(periph_run), .base_timer_run(base_timer_run),
		.ceramic_oscillator_en(ceramic_oscillator_en), .mrc_osc_en(mrc_osc_en),
		.lrc_osc_en(lrc_osc_en), .xtal_osc_en(xtal_osc_en),
		.wake_reset(wake_reset));
	ipsw_core_model core (.clk_sys(clk_sys), .rst(rst), .irq_req(irq_req),
		.ack_delay(dly), .irq_ack(ack));
	// ***********
	// helpers
	// ***********
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	task w(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task chk(input [31:0] s, input [31:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task summarize;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task enter(input [1:0] k);
		halt_q = (k == 2'h1);
		hold_q = (k == 2'h2);
		xhold_q = (k == 2'h3);
		w(1);
		{halt_q, hold_q, xhold_q} = 3'h0;
		w(1);
	endtask
	task wd;
		wdog = 1'b1;
		w(1);
		chk(wake_reset, 1'b1);
		wdog = 1'b0;
		w(1);
	endtask
	task retn;
		ret = 1'b1;
		w(1);
		ret = 1'b0;
		w(1);
	endtask
	// ***********
	// scenarios
	// ***********
	task t_map;
		for (int i = 0; i < 16; i++) begin
			src = 16'h1 << i;
			w(4);
			chk(irq_req, 1'b1);
			chk(irq_vector, {9'h0, vt[i]});
			src = 16'h0;
			w(4);
		end
	endtask
	task t_prio;
		lsel = 10'h200;
		src = 16'h8100;
		w(2);
		chk({irq_vector, irq_level}, {17'h4b, 2'h2});
		lsel = 10'h202;
		src = 16'h8002;
		w(4);
		chk({irq_vector, irq_level}, {17'h0b, 2'h3});
		lsel = 10'h0;
		src = 16'h2800;
		// timer one low skips the synchroniser and needs one edge to pass the arbiter and vector register
		w(4);
		chk(irq_vector, 17'h2b);
		src = 16'h0;
		w(4);
	endtask
	task t_nest;
		dly = 4'h5;
		src = 16'h0800;
		w(12);
		chk(service_level, 2'h1);
		src = 16'h2800;
		w(4);
		chk(irq_req, 1'b0);
		dly = 4'h0;
		lsel = 10'h200;
		src = 16'ha800;
		w(4);
		chk(service_level, 2'h2);
		src = 16'h0;
		retn;
		chk(service_level, 2'h1);
		retn;
		chk({service_level, irq_req}, 3'h0);
		lsel = 10'h0;
		dly = 4'hf;
	endtask
	task t_halt;
		enter(2'h1);
		chk({standby_state, cpu_run, periph_run}, 4'h5);
		src = 16'h2000;
		w(2);
		chk(standby_state, 2'h0);
		src = 16'h0;
		w(4);
		enter(2'h1);
		wd;
		chk(standby_state, 2'h0);
	endtask
	task t_hold;
		enter(2'h2);
		chk({standby_state, periph_run, lrc_osc_en}, 4'h9);
		src = 16'h0009;
		w(5);
		chk(standby_state, 2'h2);
		pa_lm = 1'b1;
		w(2);
		chk(standby_state, 2'h0);
		src = 16'h0;
		w(4);
		enter(2'h2);
		src = 16'h8000;
		w(2);
		chk(standby_state, 2'h0);
		src = 16'h0;
		w(4);
		pb_lm = 1'b0;
		enter(2'h2);
		src = 16'h0002;
		w(4);
		chk(standby_state, 2'h2);
		pb_lm = 1'b1;
		w(2);
		chk(standby_state, 2'h0);
		src = 16'h0;
		w(4);
	endtask
	task t_xhold;
		bt_sel = 2'h2;
		xtal_q = 1'b1;
		w(2);
		enter(2'h3);
		chk({standby_state, base_timer_run, xtal_osc_en}, 4'hf);
		xtal_q = 1'b0;
		src = 16'h0040;
		w(3);
		chk({standby_state, xtal_osc_en}, 3'h7);
		wd;
		chk(standby_state, 2'h0);
		src = 16'h0;
		bt_sel = 2'h1;
		w(4);
		enter(2'h3);
		lrc_q = 1'b0;
		w(2);
		chk(lrc_osc_en, 1'b1);
		src = 16'h0040;
		w(2);
		chk(standby_state, 2'h0);
		src = 16'h0;
		lrc_q = 1'b1;
		w(4);
	endtask
	task t_rst;
		enter(2'h2);
		rpin_n = 1'b0;
		w(3);
		chk({standby_state, wake_reset}, 3'h1);
		rpin_n = 1'b1;
		w(4);
		enter(2'h1);
		lvr = 1'b1;
		w(1);
		chk({standby_state, wake_reset}, 3'h1);
		lvr = 1'b0;
		w(2);
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			summarize;
		end
	end
	initial begin
		w(16);
		rst = 1'b0;
		w(3);
		t_map;
		t_prio;
		t_nest;
		t_halt;
		t_hold;
		t_xhold;
		t_rst;
		summarize;
	end
endmodule // ipsw_controller_bench
